// File: include/cafm_pkg.sv
// package: register map, field layout and sizes of the acceptance filter block
package cafm_pkg;
   localparam int          CAFM_NUM_FILTERS   = 16;
   localparam int          CAFM_NUM_MASKS     = 3;
   localparam int          CAFM_STD_W         = 11;
   localparam int          CAFM_EXT_W         = 18;
   localparam int          CAFM_PTR_W         = 4;
   // byte addresses (word aligned)
   localparam logic [11:0] CAFM_FSID_BASE     = 12'h000; // filter n std reg at base + 4n
   localparam logic [11:0] CAFM_FEID_BASE     = 12'h040; // filter n ext reg at base + 4n
   localparam logic [11:0] CAFM_MSEL_LO_ADDR  = 12'h080;
   localparam logic [11:0] CAFM_MSEL_HI_ADDR  = 12'h084;
   localparam logic [11:0] CAFM_MSID_BASE     = 12'h090; // mask n std reg at base + 4n
   localparam logic [11:0] CAFM_MEID_BASE     = 12'h0a0; // mask n ext reg at base + 4n
   localparam logic [11:0] CAFM_FEN_ADDR      = 12'h0b0;
   localparam logic [11:0] CAFM_BPTR_BASE     = 12'h0c0; // four pointer regs, four filters each
   localparam logic [11:0] CAFM_STAT_ADDR     = 12'h0d0;
   // std register fields
   localparam int          CAFM_SID_LSB       = 5;
   localparam int          CAFM_TYPE_BIT      = 3;
   localparam int          CAFM_EHI_LSB       = 0;
   localparam logic [15:0] CAFM_SID_WMASK     = 16'hffeb; // bits 4 and 2 unimplemented
   // selector codes, reset values and ahb transfer code
   localparam logic [1:0]  CAFM_SEL_NONE      = 2'h3;
   localparam logic [3:0]  CAFM_PTR_FIFO      = 4'hf;
   localparam logic [15:0] CAFM_FEN_RESET     = 16'hffff;
   localparam logic [15:0] CAFM_MSEL_RESET    = 16'h0000;
   localparam logic [15:0] CAFM_BPTR_RESET    = 16'h0000;
   localparam logic [1:0]  CAFM_HTRANS_NONSEQ = 2'h2;
endpackage : cafm_pkg

// File: include/cafm_cmp_if.sv
// interface: one filter entry and its mask handed to the compare unit
`timescale 1ns/1ps
interface cafm_cmp_if;
   import cafm_pkg::*;
   logic [CAFM_STD_W-1:0] f_std;
   logic [CAFM_EXT_W-1:0] f_ext;
   logic                  f_type;
   logic [CAFM_STD_W-1:0] m_std;
   logic [CAFM_EXT_W-1:0] m_ext;
   logic                  m_type;
   logic                  hit;
   modport owner (output f_std, f_ext, f_type, m_std, m_ext, m_type, input hit);
   modport unit  (input f_std, f_ext, f_type, m_std, m_ext, m_type, output hit);
endinterface : cafm_cmp_if

// File: verilog/cafm_compare.sv
// one filter versus the received identifier, under its mask
`timescale 1ns/1ps
module cafm_compare
   import cafm_pkg::*;
(
   cafm_cmp_if.unit              cmp,      // filter and mask values, hit result
   input  wire logic [CAFM_STD_W-1:0] msg_std,  // received standard id
   input  wire logic [CAFM_EXT_W-1:0] msg_ext,  // received extended id
   input  wire logic             msg_is_ext // received frame is extended
);
   logic std_ok;
   logic ext_ok;
   logic type_ok;

   // only bits set in the mask are compared
   assign std_ok  = ((cmp.f_std ^ msg_std) & cmp.m_std) == '0;
   assign ext_ok  = ((cmp.f_ext ^ msg_ext) & cmp.m_ext) == '0;
   // type bit of the filter matters only when the mask asks for it
   assign type_ok = !cmp.m_type || (cmp.f_type == msg_is_ext);
   // a standard frame has no extended bits, so they are not compared for it
   assign cmp.hit = std_ok && type_ok && (!msg_is_ext || ext_ok);
endmodule : cafm_compare

// File: verilog/cafm_top.sv
// acceptance filters and masks with AHB-Lite register access
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module cafm_top
   import cafm_pkg::*;
#(
   parameter int NUM_FILTERS = CAFM_NUM_FILTERS, // number of filters
   parameter int NUM_MASKS   = CAFM_NUM_MASKS    // number of masks
)(
   input  wire logic                  clk,         // 20 MHz module clock
   input  wire logic                  rst_n,       // async reset, active low
   input  wire logic                  clk_en,      // freezes all state while low
   input  wire logic                  hsel,        // ahb slave select
   input  wire logic [11:0]           haddr,       // ahb byte address
   input  wire logic [1:0]            htrans,      // ahb transfer type
   input  wire logic                  hwrite,      // ahb write
   input  wire logic [2:0]            hsize,       // ahb size
   input  wire logic                  hready,      // ahb bus ready
   input  wire logic [31:0]           hwdata,      // ahb write data
   output logic      [31:0]           hrdata,      // ahb read data
   output logic                       hreadyout,   // ahb slave ready
   output logic                       hresp,       // ahb response, always okay
   input  wire logic                  id_valid,    // one-cycle strobe: identifier present
   input  wire logic [CAFM_STD_W-1:0] id_std,      // received standard identifier
   input  wire logic [CAFM_EXT_W-1:0] id_ext,      // received extended identifier
   input  wire logic                  id_is_ext,   // received frame is extended
   output logic                       res_valid,   // one-cycle result strobe
   output logic                       res_hit,     // some enabled filter matched
   output logic [3:0]                 res_filter,  // lowest matching filter
   output logic [CAFM_PTR_W-1:0]      res_pointer, // buffer of that filter, 1111 = fifo
   output logic                       res_to_fifo  // result goes to receive fifo
);
   // the register map has fixed windows, so only the documented sizes fit
   if (NUM_FILTERS != CAFM_NUM_FILTERS || NUM_MASKS != CAFM_NUM_MASKS)
   begin : g_bad_size
      $error("cafm_top: register map serves exactly 16 filters and 3 masks");
   end

   // filter and mask storage
   logic [CAFM_STD_W-1:0] f_std   [NUM_FILTERS];
   logic [CAFM_EXT_W-1:0] f_ext   [NUM_FILTERS];
   logic                  f_type  [NUM_FILTERS];
   logic [CAFM_STD_W-1:0] m_std   [NUM_MASKS];
   logic [CAFM_EXT_W-1:0] m_ext   [NUM_MASKS];
   logic                  m_type  [NUM_MASKS];
   logic [15:0]           msel_lo;
   logic [15:0]           msel_hi;
   logic [15:0]           filt_en;
   logic [15:0]           bptr    [4];
   logic [15:0]           hit_count;

   // ahb address phase capture
   logic        ph_write;
   logic        ph_read;
   logic [11:0] ph_addr;
   logic        take;
   logic [31:0] next_rdata;

   // which mask a filter uses; code 11 means all identifier bits compared, frame type not enforced
   function automatic logic [1:0] cafm_sel(input int k, input logic [15:0] lo, input logic [15:0] hi);
      logic [31:0] all;
      all = {hi, lo};
      return all[2*k +: 2];
   endfunction : cafm_sel

   // decode base + 4n within a window of n entries; returns index or -1
   function automatic int cafm_idx(input logic [11:0] a, input logic [11:0] base, input int n);
      int d;
      d = int'(a) - int'(base);
      if (d >= 0 && d < 4*n && d[1:0] == 2'b00)
         return d / 4;
      return -1;
   endfunction : cafm_idx

   // hreadyout stays high while clk_en is low, so a transfer then finishes on the bus
   // but is lost: software must not touch the block while it is frozen
   assign take = hsel && hready && (htrans == CAFM_HTRANS_NONSEQ);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ph_write <= 1'b0;
         ph_read  <= 1'b0;
         ph_addr  <= 12'h000;
      end
      else if (clk_en)
      begin
         ph_write <= take && hwrite;
         ph_read  <= take && !hwrite;
         ph_addr  <= haddr;
      end
   end

   // filter entries, written in the data phase; unimplemented bits are never stored
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_FILTERS; i++)
         begin
            f_std[i]  <= '0;
            f_ext[i]  <= '0;
            f_type[i] <= 1'b0;
         end
      end
      else if (clk_en && ph_write)
      begin
         for (int i = 0; i < NUM_FILTERS; i++)
         begin
            if (cafm_idx(ph_addr, CAFM_FSID_BASE, NUM_FILTERS) == i)
            begin
               f_std[i]        <= hwdata[CAFM_SID_LSB +: CAFM_STD_W];
               f_type[i]       <= hwdata[CAFM_TYPE_BIT];
               f_ext[i][17:16] <= hwdata[CAFM_EHI_LSB +: 2];
            end
            if (cafm_idx(ph_addr, CAFM_FEID_BASE, NUM_FILTERS) == i)
               f_ext[i][15:0] <= hwdata[15:0];
         end
      end
   end

   // mask entries; the type-match bit shares the standard word
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int j = 0; j < NUM_MASKS; j++)
         begin
            m_std[j]  <= '0;
            m_ext[j]  <= '0;
            m_type[j] <= 1'b0;
         end
      end
      else if (clk_en && ph_write)
      begin
         for (int j = 0; j < NUM_MASKS; j++)
         begin
            if (cafm_idx(ph_addr, CAFM_MSID_BASE, NUM_MASKS) == j)
            begin
               m_std[j]        <= hwdata[CAFM_SID_LSB +: CAFM_STD_W];
               m_type[j]       <= hwdata[CAFM_TYPE_BIT];
               m_ext[j][17:16] <= hwdata[CAFM_EHI_LSB +: 2];
            end
            if (cafm_idx(ph_addr, CAFM_MEID_BASE, NUM_MASKS) == j)
               m_ext[j][15:0] <= hwdata[15:0];
         end
      end
   end

   // mask selectors, two bits per filter
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         msel_lo <= CAFM_MSEL_RESET;
         msel_hi <= CAFM_MSEL_RESET;
      end
      else if (clk_en && ph_write)
      begin
         if (ph_addr == CAFM_MSEL_LO_ADDR)
            msel_lo <= hwdata[15:0];
         if (ph_addr == CAFM_MSEL_HI_ADDR)
            msel_hi <= hwdata[15:0];
      end
   end

   // filters come out of reset enabled, so a cleared mask accepts everything
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         filt_en <= CAFM_FEN_RESET;
      else if (clk_en && ph_write && ph_addr == CAFM_FEN_ADDR)
         filt_en <= hwdata[15:0];
   end

   // buffer pointers, four filters to a word
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int b = 0; b < 4; b++)
            bptr[b] <= CAFM_BPTR_RESET;
      end
      else if (clk_en && ph_write)
      begin
         for (int b = 0; b < 4; b++)
            if (cafm_idx(ph_addr, CAFM_BPTR_BASE, 4) == b)
               bptr[b] <= hwdata[15:0];
      end
   end

   // read mux, prepared from the address phase so data stand in the data phase
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      for (int i = 0; i < NUM_FILTERS; i++)
      begin
         if (cafm_idx(haddr, CAFM_FSID_BASE, NUM_FILTERS) == i)
            next_rdata[15:0] = {f_std[i], 1'b0, f_type[i], 1'b0, f_ext[i][17:16]} & CAFM_SID_WMASK;
         if (cafm_idx(haddr, CAFM_FEID_BASE, NUM_FILTERS) == i)
            next_rdata[15:0] = f_ext[i][15:0];
      end
      for (int j = 0; j < NUM_MASKS; j++)
      begin
         if (cafm_idx(haddr, CAFM_MSID_BASE, NUM_MASKS) == j)
            next_rdata[15:0] = {m_std[j], 1'b0, m_type[j], 1'b0, m_ext[j][17:16]} & CAFM_SID_WMASK;
         if (cafm_idx(haddr, CAFM_MEID_BASE, NUM_MASKS) == j)
            next_rdata[15:0] = m_ext[j][15:0];
      end
      if (haddr == CAFM_MSEL_LO_ADDR)
         next_rdata[15:0] = msel_lo;
      if (haddr == CAFM_MSEL_HI_ADDR)
         next_rdata[15:0] = msel_hi;
      if (haddr == CAFM_FEN_ADDR)
         next_rdata[15:0] = filt_en;
      for (int b = 0; b < 4; b++)
         if (cafm_idx(haddr, CAFM_BPTR_BASE, 4) == b)
            next_rdata[15:0] = bptr[b];
      if (haddr == CAFM_STAT_ADDR)
         next_rdata[15:0] = hit_count;
   end

   // zero wait states and always okay; unmapped writes are dropped
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else if (clk_en)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // read data loaded at the address phase edge, so it stands through the data phase
   // trade-off: a read straight after a write to the same word sees the old value
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         hrdata <= 32'h0000_0000;
      else if (clk_en && take && !hwrite)
         hrdata <= next_rdata;
   end

   // per-filter compare units
   logic [NUM_FILTERS-1:0] hits;

   for (genvar k = 0; k < NUM_FILTERS; k++)
   begin : g_filt
      cafm_cmp_if c ();
      logic [1:0] sel;
      assign sel      = cafm_sel(k, msel_lo, msel_hi);
      assign c.f_std  = f_std[k];
      assign c.f_ext  = f_ext[k];
      assign c.f_type = f_type[k];
      // no mask: every identifier bit compared, frame type not enforced
      assign c.m_std  = (sel == CAFM_SEL_NONE) ? '1 : m_std[sel];
      assign c.m_ext  = (sel == CAFM_SEL_NONE) ? '1 : m_ext[sel];
      assign c.m_type = (sel == CAFM_SEL_NONE) ? 1'b0 : m_type[sel];
      cafm_compare u_cmp (
         .cmp        (c.unit),
         .msg_std    (id_std),
         .msg_ext    (id_ext),
         .msg_is_ext (id_is_ext)
      );
      assign hits[k] = c.hit && filt_en[k];
   end

   // lowest numbered hit wins, as filters are scanned from 15 down to 0 and the last hit overrides
   logic                  any_hit;
   logic [3:0]            win;
   logic [CAFM_PTR_W-1:0] win_ptr;

   always_comb
   begin
      any_hit = 1'b0;
      win     = 4'h0;
      for (int k = NUM_FILTERS-1; k >= 0; k--)
         if (hits[k])
         begin
            any_hit = 1'b1;
            win     = 4'(k);
         end
      win_ptr = bptr[win[3:2]][4*win[1:0] +: CAFM_PTR_W];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         res_valid   <= 1'b0;
         res_hit     <= 1'b0;
         res_filter  <= 4'h0;
         res_pointer <= 4'h0;
         res_to_fifo <= 1'b0;
      end
      else if (clk_en)
      begin
         res_valid <= id_valid;
         if (id_valid)
         begin
            res_hit     <= any_hit;
            res_filter  <= win;
            res_pointer <= any_hit ? win_ptr : 4'h0;
            res_to_fifo <= any_hit && (win_ptr == CAFM_PTR_FIFO);
         end
      end
   end

   // count of accepted identifiers, readable as block status
   // it wraps silently; software compares two readings rather than one
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         hit_count <= 16'h0000;
      else if (clk_en && id_valid && any_hit)
         hit_count <= hit_count + 16'h0001;
   end
endmodule : cafm_top

// File: sim/cafm_engine_model.sv
// model of the protocol engine that hands received identifiers to the filter block
`timescale 1ns/1ps
module cafm_engine_model
   import cafm_pkg::*;
(
   input  wire logic                  clk,      // module clock
   output logic                       id_valid, // identifier strobe
   output logic      [CAFM_STD_W-1:0] id_std,   // standard id
   output logic      [CAFM_EXT_W-1:0] id_ext,   // extended id
   output logic                       id_is_ext // frame is extended
);
   logic [CAFM_STD_W+CAFM_EXT_W:0] pend [$];

   initial
   begin
      id_valid  = 1'b0;
      id_std    = '0;
      id_ext    = '0;
      id_is_ext = 1'b0;
   end

   // id lines toggle between strobes so a stale value can never pass for a fresh one
   always @(posedge clk)
   begin
      if (pend.size() > 0)
      begin
         {id_std, id_ext, id_is_ext} <= pend.pop_front();
         id_valid                    <= 1'b1;
      end
      else
      begin
         id_valid  <= 1'b0;
         id_std    <= ~id_std;
         id_ext    <= ~id_ext;
         id_is_ext <= ~id_is_ext;
      end
   end

   task automatic send(input logic [CAFM_STD_W-1:0] s, input logic [CAFM_EXT_W-1:0] e, input logic x);
      pend.push_back({s, e, x});
   endtask : send
endmodule : cafm_engine_model

// File: sim/cafm_top_chk.sv
// checker: bus answers and result timing of the acceptance filter block
`timescale 1ns/1ps
module cafm_top_chk
   import cafm_pkg::*;
(
   input wire logic                  clk,        // clock
   input wire logic                  rst_n,      // reset
   input wire logic                  clk_en,     // run enable
   input wire logic                  hsel,       // select
   input wire logic [11:0]           haddr,      // address
   input wire logic [1:0]            htrans,     // transfer type
   input wire logic                  hwrite,     // write
   input wire logic                  hready,     // bus ready
   input wire logic [31:0]           hrdata,     // read data
   input wire logic                  hreadyout,  // slave ready
   input wire logic                  hresp,      // response
   input wire logic                  id_valid,   // id strobe
   input wire logic                  res_valid,  // result strobe
   input wire logic                  res_hit,    // hit
   input wire logic [3:0]            res_filter, // filter
   input wire logic [CAFM_PTR_W-1:0] res_pointer,// pointer
   input wire logic                  res_to_fifo // fifo
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence rd_taken;
      hsel && hready && clk_en && htrans == CAFM_HTRANS_NONSEQ && !hwrite;
   endsequence
   sequence std_rd;
      rd_taken ##0 (haddr < CAFM_FEID_BASE || (haddr >= CAFM_MSID_BASE && haddr < CAFM_MEID_BASE));
   endsequence

   chk_result_late: assert property (id_valid && clk_en |=> res_valid)
      else $error("result strobe missing");
   chk_result_pulse: assert property (!id_valid && clk_en |=> !res_valid)
      else $error("result strobe without id");
   chk_fifo_flag: assert property (res_valid |-> res_to_fifo == (res_hit && res_pointer == CAFM_PTR_FIFO))
      else $error("fifo flag wrong");
   chk_miss_clear: assert property (res_valid && !res_hit |-> res_pointer == 4'h0 && !res_to_fifo)
      else $error("miss reports a buffer");
   chk_result_hold: assert property (!id_valid && clk_en |=> $stable({res_hit, res_filter, res_pointer}))
      else $error("result changed without id");
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or error");
   chk_unimpl_zero: assert property (std_rd |=> hrdata[4] == 1'b0 && hrdata[2] == 1'b0)
      else $error("unimplemented bit read one");
   chk_upper_zero: assert property (rd_taken |=> hrdata[31:16] == 16'h0000)
      else $error("upper half not zero");
   chk_unmapped_zero: assert property (rd_taken ##0 haddr >= 12'h0d4 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule : cafm_top_chk

bind cafm_top cafm_top_chk cafm_top_chk_inst (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .id_valid(id_valid), .res_valid(res_valid), .res_hit(res_hit), .res_filter(res_filter),
   .res_pointer(res_pointer), .res_to_fifo(res_to_fifo));

// File: sim/can_acceptance_filter_mask_tb.sv
// testbench: register access and randomised acceptance against a reference
`timescale 1ns/1ps
module can_acceptance_filter_mask_tb;
   import cafm_pkg::*;
   logic clk, rst_n, clk_en, hsel, hwrite, hready, hresp, rd_ph;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, v;
   logic id_valid, id_is_ext, res_valid, res_hit, res_to_fifo, x;
   logic [10:0] id_std, s;
   logic [17:0] id_ext, e;
   logic [3:0] res_filter, res_pointer;
   logic [15:0] sh [45];
   logic [9:0] ev, eo;
   logic [9:0] exq [$];
   logic [31:0] rdq [$];
   int miscompares, total_checks, hits, j;

   cafm_top cafm_top_inst (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .id_valid(id_valid), .id_std(id_std), .id_ext(id_ext),
      .id_is_ext(id_is_ext), .res_valid(res_valid), .res_hit(res_hit), .res_filter(res_filter),
      .res_pointer(res_pointer), .res_to_fifo(res_to_fifo));
   cafm_engine_model cafm_engine_model_inst (.clk(clk), .id_valid(id_valid), .id_std(id_std),
      .id_ext(id_ext), .id_is_ext(id_is_ext));

   always #25 clk = ~clk;

   task automatic check(input logic [31:0] ex, input logic [31:0] ac);
      total_checks++;
      if (ac !== ex)
      begin
         miscompares++;
         $display("unexpected at %0t: expected %h got %h", $time, ex, ac);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   // index order: filter std, filter ext, selects, mask std, mask ext, enables, pointers
   function automatic logic [11:0] addr_of(input int i);
      if (i < 32)
         return CAFM_FSID_BASE + 12'(4 * i);
      if (i < 34)
         return CAFM_MSEL_LO_ADDR + 12'(4 * (i - 32));
      if (i < 37)
         return CAFM_MSID_BASE + 12'(4 * (i - 34));
      if (i < 40)
         return CAFM_MEID_BASE + 12'(4 * (i - 37));
      if (i == 40)
         return CAFM_FEN_ADDR;
      return CAFM_BPTR_BASE + 12'(4 * (i - 41));
   endfunction : addr_of

   function automatic logic [9:0] ref_res(input logic [29:0] m);
      logic [10:0] ms;
      logic [17:0] me;
      logic mt;
      logic [1:0] sl;
      logic [3:0] p;
      for (int k = 0; k < 16; k++)
      begin
         sl = sh[32 + k / 8][2 * (k % 8) +: 2];
         ms = '1;
         me = '1;
         mt = 1'b0;
         if (sl != CAFM_SEL_NONE)
         begin
            ms = sh[34 + sl][15:5];
            me = {sh[34 + sl][1:0], sh[37 + sl]};
            mt = sh[34 + sl][3];
         end
         p = sh[41 + k / 4][4 * (k % 4) +: 4];
         if (sh[40][k] && ((m[29:19] ^ sh[k][15:5]) & ms) == 11'h0
             && (!m[0] || ((m[18:1] ^ {sh[k][1:0], sh[16 + k]}) & me) == 18'h0)
             && (!mt || sh[k][3] == m[0]))
            return {1'b1, 4'(k), p, p == CAFM_PTR_FIFO};
      end
      return 10'h0;
   endfunction : ref_res

   // master side: address phase held until ready, then data phase held until ready
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= CAFM_HTRANS_NONSEQ;
      haddr  <= a;
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
   endtask : ahb

   task automatic rd(input logic [11:0] a, input logic [15:0] ex);
      rdq.push_back({16'h0, ex});
      ahb(1'b0, a, 32'h0);
   endtask : rd

   always @(posedge clk)
   begin
      // a data phase lasts until hready is seen high, so the flag only moves then
      if (hready === 1'b1)
         rd_ph <= hsel && htrans == CAFM_HTRANS_NONSEQ && !hwrite;
      if (rd_ph === 1'b1 && hready === 1'b1)
         check(rdq.pop_front(), hrdata);
      if (res_valid === 1'b1)
      begin
         eo = exq.pop_front();
         check(32'(eo), 32'({res_hit, eo[9] ? res_filter : 4'h0, res_pointer, res_to_fifo}));
      end
   end

   initial
   begin
      repeat (40000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end

   initial
   begin
      {clk, rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
      clk_en = 1'b1;
      hsize  = 3'h2;
      void'($urandom(32'hf37407c3));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 45; i++)
         sh[i] = (i == 40) ? CAFM_FEN_RESET : 16'h0;
      for (int i = 0; i < 45; i++)
         rd(addr_of(i), sh[i]);
      rd(CAFM_STAT_ADDR, 16'h0);
      rd(12'h0fc, 16'h0);
      for (int r = 0; r < 8; r++)
      begin
         for (int i = 0; i < 45; i++)
         begin
            v = $urandom;
            sh[i] = v[15:0] & ((i < 16 || (i > 33 && i < 37)) ? CAFM_SID_WMASK : 16'hffff);
            ahb(1'b1, addr_of(i), v);
         end
         for (int i = 0; i < 45; i++)
            rd(addr_of(i), sh[i]);
         for (int n = 0; n < 24; n++)
         begin
            j = $urandom_range(15);
            x = 1'($urandom);
            s = sh[j][15:5] ^ (11'($urandom) & 11'($urandom) & 11'($urandom));
            e = {sh[j][1:0], sh[16 + j]} ^ (18'($urandom) & 18'($urandom) & 18'($urandom));
            ev = ref_res({s, e, x});
            exq.push_back(ev);
            hits += int'(ev[9]);
            cafm_engine_model_inst.send(s, e, x);
            if ($urandom_range(1) == 1)
               @(posedge clk);
         end
         wait (exq.size() == 0);
         @(posedge clk);
      end
      rd(CAFM_STAT_ADDR, 16'(hits));
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(CAFM_FEN_ADDR, CAFM_FEN_RESET);
      rd(CAFM_STAT_ADDR, 16'h0);
      for (int i = 0; i < 45; i++)
         sh[i] = (i == 40) ? CAFM_FEN_RESET : 16'h0;
      // frozen block: both the write and the identifier must be lost
      clk_en <= 1'b0;
      ahb(1'b1, CAFM_FEN_ADDR, 32'h0000_0000);
      cafm_engine_model_inst.send(11'($urandom), 18'($urandom), 1'b0);
      repeat (3) @(posedge clk);
      clk_en <= 1'b1;
      rd(CAFM_FEN_ADDR, CAFM_FEN_RESET);
      rd(CAFM_STAT_ADDR, 16'h0);
      s = 11'($urandom);
      e = 18'($urandom);
      x = 1'($urandom);
      ev = ref_res({s, e, x});
      exq.push_back(ev);
      cafm_engine_model_inst.send(s, e, x);
      wait (exq.size() == 0);
      @(posedge clk);
      rd(CAFM_STAT_ADDR, 16'(ev[9]));
      repeat (2) @(posedge clk);
      tally_and_finish();
   end
endmodule : can_acceptance_filter_mask_tb
